//--- design/dvm_regs.svh
// constants for the dvm sync and complete handler
`ifndef DVM_REGS_SVH
`define DVM_REGS_SVH

// snoop encodings that mark a dvm message on the address channels
`define DVM_AR_SNOOP     4'hf
`define DVM_AC_SNOOP     4'hf

// message type field inside the address of the first part
`define DVM_TYPE_MSB     14
`define DVM_TYPE_LSB     12
`define DVM_TYPE_TLBI    3'h0
`define DVM_TYPE_BPI     3'h1
`define DVM_TYPE_ICPA    3'h2
`define DVM_TYPE_ICVA    3'h3
`define DVM_TYPE_SYNC    3'h4
`define DVM_TYPE_CMPL    3'h6

// address bit that announces a second part
`define DVM_MULTI_BIT    0

// snoop response codes
`define DVM_CR_OK        5'h00
`define DVM_CR_FAIL      5'h02

// read response bit that reports cannot-perform
`define DVM_RRESP_FAIL   1

// transaction id reserved for dvm traffic only
`define DVM_ID           4'hf

// pending received syncs that must be held
`define DVM_SYNC_MAX     9'h100

// own requests still awaiting read data
`define DVM_AR_OUT_MAX   4'hf

`endif

//--- design/dvm_pkg.sv
// types shared by the dvm handler modules
package dvm_pkg;

    typedef logic [2:0]  dvm_kind_t;
    typedef logic [31:0] dvm_addr_t;
    typedef logic [8:0]  sync_count_t;

    // read address issue sequence, gray along idle, send1, send2
    typedef enum logic [1:0]
    {
        A_IDLE  = 2'b00,
        A_SEND1 = 2'b01,
        A_SEND2 = 2'b11
    } ar_state_t;

    // snoop handling sequence
    typedef enum logic [0:0]
    {
        S_IDLE = 1'b0,
        S_RESP = 1'b1
    } snp_state_t;

endpackage : dvm_pkg

//--- design/dvm_evt_if.sv
// events passed between the snoop side, the tracker and the issue side
`timescale 1ns/1ps
interface dvm_evt_if;
    import dvm_pkg::*;

    logic        sync_rcvd;
    logic        cmpl_rcvd;
    logic        cmpl_issued;
    sync_count_t pending;
    logic        pending_nz;

    modport snoop (output sync_rcvd, output cmpl_rcvd);
    modport track (input sync_rcvd, input cmpl_issued,
                   output pending, output pending_nz);
    modport core  (input sync_rcvd, input cmpl_rcvd, input pending,
                   input pending_nz, output cmpl_issued);
endinterface : dvm_evt_if

//--- design/dvm_sync_tracker.sv
// count of received syncs still awaiting our dvm complete
`timescale 1ns/1ps
`include "dvm_regs.svh"
module dvm_sync_tracker
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // events
    dvm_evt_if.track  evt
);
    import dvm_pkg::*;

    // only the number matters, so no per-sync record is kept
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            evt.pending <= 9'h000;
        else if (evt.sync_rcvd && !evt.cmpl_issued)
            evt.pending <= evt.pending + 9'h001;
        else if (!evt.sync_rcvd && evt.cmpl_issued)
            evt.pending <= evt.pending - 9'h001;
    end

    // flag kept as its own flop so the issue logic sees no adder
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            evt.pending_nz <= 1'b0;
        else if (evt.sync_rcvd)
            evt.pending_nz <= 1'b1;
        else if (evt.cmpl_issued)
            evt.pending_nz <= (evt.pending != 9'h001);
    end

    AST_PENDING_MAX: assert property (@(posedge clk) disable iff (rst)
        evt.pending <= `DVM_SYNC_MAX)
        else $error("pending sync count above limit");

    AST_PENDING_STEP: assert property (@(posedge clk) disable iff (rst)
        (evt.sync_rcvd && !evt.cmpl_issued)
        |=> evt.pending == $past(evt.pending) + 9'h001)
        else $error("pending count missed a received sync");

endmodule : dvm_sync_tracker

//--- design/dvm_snoop_responder.sv
// snoop address acceptance and snoop response for dvm messages
`timescale 1ns/1ps
`include "dvm_regs.svh"
module dvm_snoop_responder
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // snoop address
    input  wire logic              ac_valid,
    input  wire dvm_pkg::dvm_addr_t ac_addr,
    input  wire logic [3:0]        ac_snoop,
    output logic                   ac_ready,
    // snoop response
    output logic                   cr_valid,
    input  wire logic              cr_ready,
    output logic [4:0]             cr_resp,
    // local invalidation request
    output logic                   inv_valid,
    output dvm_pkg::dvm_kind_t     inv_kind,
    output dvm_pkg::dvm_addr_t     inv_addr,
    output dvm_pkg::dvm_addr_t     inv_addr2,
    // events
    dvm_evt_if.snoop               evt
);
    import dvm_pkg::*;

    snp_state_t state;
    logic       second;
    logic [4:0] held_resp;
    logic       ac_hs;
    logic       cr_hs;
    logic       is_dvm;
    dvm_kind_t  kind;
    logic [4:0] next_resp;

    assign ac_hs  = ac_valid && ac_ready;
    assign cr_hs  = cr_valid && cr_ready;
    assign is_dvm = (ac_snoop == `DVM_AC_SNOOP);
    assign kind   = ac_addr[`DVM_TYPE_MSB:`DVM_TYPE_LSB];

    // both icache forms are taken; sync and complete never fail
    always_comb
    begin
        next_resp = `DVM_CR_OK;
        if (is_dvm && second)
            next_resp = held_resp;
        else if (is_dvm)
        begin
            unique case (kind)
                `DVM_TYPE_TLBI, `DVM_TYPE_BPI,
                `DVM_TYPE_ICPA, `DVM_TYPE_ICVA:
                    next_resp = `DVM_CR_OK;
                `DVM_TYPE_SYNC, `DVM_TYPE_CMPL:
                    next_resp = `DVM_CR_OK;
                default:
                    next_resp = `DVM_CR_FAIL;
            endcase
        end
    end

    // one snoop at a time; never waits on pending syncs
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state    <= S_IDLE;
            ac_ready <= 1'b0;
            cr_valid <= 1'b0;
            cr_resp  <= `DVM_CR_OK;
        end
        else
        begin
            unique case (state)
                S_IDLE:
                begin
                    ac_ready <= 1'b1;
                    if (ac_hs)
                    begin
                        state    <= S_RESP;
                        ac_ready <= 1'b0;
                        cr_valid <= 1'b1;
                        cr_resp  <= next_resp;
                    end
                end
                S_RESP:
                    if (cr_hs)
                    begin
                        state    <= S_IDLE;
                        cr_valid <= 1'b0;
                        ac_ready <= 1'b1;
                    end
            endcase
        end
    end

    // multi-part tracking: the second part reuses the first answer
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            second    <= 1'b0;
            held_resp <= `DVM_CR_OK;
        end
        else if (ac_hs && is_dvm)
        begin
            second    <= !second && ac_addr[`DVM_MULTI_BIT]
                         && kind != `DVM_TYPE_SYNC
                         && kind != `DVM_TYPE_CMPL;
            held_resp <= next_resp;
        end
    end

    // events and invalidation requests, one cycle pulses
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            evt.sync_rcvd <= 1'b0;
            evt.cmpl_rcvd <= 1'b0;
            inv_valid     <= 1'b0;
            inv_kind      <= `DVM_TYPE_TLBI;
            inv_addr      <= 32'h0000_0000;
            inv_addr2     <= 32'h0000_0000;
        end
        else
        begin
            evt.sync_rcvd <= ac_hs && is_dvm && !second
                             && kind == `DVM_TYPE_SYNC;
            evt.cmpl_rcvd <= ac_hs && is_dvm && !second
                             && kind == `DVM_TYPE_CMPL;
            inv_valid     <= ac_hs && is_dvm && next_resp == `DVM_CR_OK
                             && (second || !ac_addr[`DVM_MULTI_BIT])
                             && (second || kind < `DVM_TYPE_SYNC);
            if (ac_hs && is_dvm && !second)
            begin
                inv_kind  <= kind;
                inv_addr  <= ac_addr;
                inv_addr2 <= 32'h0000_0000;
            end
            else if (ac_hs && is_dvm)
                inv_addr2 <= ac_addr;
        end
    end

    sequence snoop_taken;
        ac_valid && ac_ready;
    endsequence

    AST_SYNC_NEVER_FAIL: assert property (@(posedge clk) disable iff (rst)
        (snoop_taken and (is_dvm && !second
            && (kind == `DVM_TYPE_SYNC || kind == `DVM_TYPE_CMPL)))
        |=> cr_valid && cr_resp == `DVM_CR_OK)
        else $error("sync or complete answered with fail");

    AST_SAME_RESP_PARTS: assert property (@(posedge clk) disable iff (rst)
        (snoop_taken and (is_dvm && second))
        |=> cr_resp == $past(held_resp))
        else $error("second part answered differently");

    AST_ACCEPT_AGAIN: assert property (@(posedge clk) disable iff (rst)
        (cr_valid && cr_ready) |=> ac_ready && !cr_valid)
        else $error("snoop channel not reopened after response");

endmodule : dvm_snoop_responder

//--- design/dvm_sync_complete_handler.sv
// dvm message handling on the read address and snoop channels
`timescale 1ns/1ps
`include "dvm_regs.svh"
// Summary of operation
// - only one own sync outstanding
// - hold up to 256 received syncs
// - keep accepting snoops while syncs pend
// - no new operations while received syncs pend
// - complete never waits on own sync
// - complete only after local work drained
// - issue messages on read address channel
// - acknowledge every snoop on response channel
// - complete only after sync snoop handshake
// - message parts sent back to back
// - later parts need no outside action
// - each part answered, identical answer
// - all parts share one id
// - okay if supported, fail otherwise
// - sync and complete never answered fail
// - no data; read beat is acknowledgement
// - dvm id kept apart from reads
// - operations ordered before later sync
// - accept both icache invalidation forms
module dvm_sync_complete_handler
(
    // clock and reset
    input  wire logic               CLK,
    input  wire logic               RST,
    // local operation request, held until OP_ACK
    input  wire logic               OP_REQ,
    input  wire dvm_pkg::dvm_addr_t OP_ADDR,
    input  wire dvm_pkg::dvm_addr_t OP_ADDR2,
    output logic                    OP_ACK,
    // local sync request, held until SYNC_ACK
    input  wire logic               SYNC_REQ,
    output logic                    SYNC_ACK,
    output logic                    SYNC_DONE,
    // local work finished for received syncs
    input  wire logic               LOCAL_DRAINED,
    // read address channel
    output logic                    ARVALID,
    input  wire logic               ARREADY,
    output dvm_pkg::dvm_addr_t      ARADDR,
    output logic [3:0]              ARID,
    output logic [3:0]              ARSNOOP,
    // read data channel
    input  wire logic               RVALID,
    output logic                    RREADY,
    input  wire logic [3:0]         RRESP,
    input  wire logic               RLAST,
    // snoop address channel
    input  wire logic               ACVALID,
    output logic                    ACREADY,
    input  wire dvm_pkg::dvm_addr_t ACADDR,
    input  wire logic [3:0]         ACSNOOP,
    // snoop response channel
    output logic                    CRVALID,
    input  wire logic               CRREADY,
    output logic [4:0]              CRRESP,
    // local invalidation and status
    output logic                    INV_VALID,
    output dvm_pkg::dvm_kind_t      INV_KIND,
    output dvm_pkg::dvm_addr_t      INV_ADDR,
    output dvm_pkg::dvm_addr_t      INV_ADDR2,
    output logic                    DVM_FAULT,
    output dvm_pkg::sync_count_t    PENDING_SYNCS
);
    import dvm_pkg::*;

    dvm_evt_if evt ();

    ar_state_t  state;
    logic       own_sync;
    logic [3:0] ar_out;
    logic       multi;
    logic       is_op;
    logic       is_sync;
    logic       ar_hs;
    logic       r_hs;
    logic       pick_cmpl;
    logic       pick_op;
    logic       pick_sync;

    assign ar_hs = ARVALID && ARREADY;
    assign r_hs  = RVALID && RREADY;

    // complete first so received syncs never wait on our own; the count
    // drops two edges after the handshake, so skip while that is in flight
    assign pick_cmpl = evt.pending_nz && LOCAL_DRAINED
                       && !evt.cmpl_issued
                       && ar_out != `DVM_AR_OUT_MAX;
    assign pick_op   = !pick_cmpl && OP_REQ && !OP_ACK
                       && !evt.pending_nz
                       && ar_out < `DVM_AR_OUT_MAX - 4'h1;
    assign pick_sync = !pick_cmpl && !pick_op && SYNC_REQ && !SYNC_ACK
                       && !own_sync && ar_out == 4'h0;

    dvm_snoop_responder u_snoop
    (
        .clk       (CLK),
        .rst       (RST),
        .ac_valid  (ACVALID),
        .ac_addr   (ACADDR),
        .ac_snoop  (ACSNOOP),
        .ac_ready  (ACREADY),
        .cr_valid  (CRVALID),
        .cr_ready  (CRREADY),
        .cr_resp   (CRRESP),
        .inv_valid (INV_VALID),
        .inv_kind  (INV_KIND),
        .inv_addr  (INV_ADDR),
        .inv_addr2 (INV_ADDR2),
        .evt       (evt.snoop)
    );

    dvm_sync_tracker u_track
    (
        .clk (CLK),
        .rst (RST),
        .evt (evt.track)
    );

    // read address sequencing; second part follows with no gap
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            state   <= A_IDLE;
            ARVALID <= 1'b0;
            ARADDR  <= 32'h0000_0000;
            ARID    <= `DVM_ID;
            ARSNOOP <= `DVM_AR_SNOOP;
            multi   <= 1'b0;
            is_op   <= 1'b0;
            is_sync <= 1'b0;
        end
        else
        begin
            unique case (state)
                A_IDLE:
                begin
                    ARID    <= `DVM_ID;
                    ARSNOOP <= `DVM_AR_SNOOP;
                    if (pick_cmpl)
                    begin
                        state   <= A_SEND1;
                        ARVALID <= 1'b1;
                        ARADDR  <= {17'h00000, `DVM_TYPE_CMPL, 12'h000};
                        multi   <= 1'b0;
                        is_op   <= 1'b0;
                        is_sync <= 1'b0;
                    end
                    else if (pick_op)
                    begin
                        state   <= A_SEND1;
                        ARVALID <= 1'b1;
                        ARADDR  <= OP_ADDR;
                        multi   <= OP_ADDR[`DVM_MULTI_BIT];
                        is_op   <= 1'b1;
                        is_sync <= 1'b0;
                    end
                    else if (pick_sync)
                    begin
                        state   <= A_SEND1;
                        ARVALID <= 1'b1;
                        ARADDR  <= {17'h00000, `DVM_TYPE_SYNC, 12'h000};
                        multi   <= 1'b0;
                        is_op   <= 1'b0;
                        is_sync <= 1'b1;
                    end
                end
                A_SEND1:
                    if (ar_hs && multi)
                    begin
                        state  <= A_SEND2;
                        ARADDR <= OP_ADDR2;
                    end
                    else if (ar_hs)
                    begin
                        state   <= A_IDLE;
                        ARVALID <= 1'b0;
                    end
                A_SEND2:
                    if (ar_hs)
                    begin
                        state   <= A_IDLE;
                        ARVALID <= 1'b0;
                    end
                default:
                begin
                    state   <= A_IDLE;
                    ARVALID <= 1'b0;
                end
            endcase
        end
    end

    // handshake pulses back to the local requesters and the tracker
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            OP_ACK          <= 1'b0;
            SYNC_ACK        <= 1'b0;
            evt.cmpl_issued <= 1'b0;
        end
        else
        begin
            OP_ACK   <= ar_hs && is_op
                        && (state == A_SEND2 || !multi);
            SYNC_ACK <= ar_hs && is_sync;
            evt.cmpl_issued <= ar_hs && !is_op && !is_sync;
        end
    end

    // own sync stays open until the far end forwards a complete
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            own_sync  <= 1'b0;
            SYNC_DONE <= 1'b0;
        end
        else
        begin
            if (ar_hs && is_sync)
                own_sync <= 1'b1;
            else if (evt.cmpl_rcvd)
                own_sync <= 1'b0;
            SYNC_DONE <= evt.cmpl_rcvd && own_sync;
        end
    end

    // requests awaiting their read beat; caps keep the count in range
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            ar_out <= 4'h0;
        else if (ar_hs && !r_hs)
            ar_out <= ar_out + 4'h1;
        else if (!ar_hs && r_hs && ar_out != 4'h0)
            ar_out <= ar_out - 4'h1;
    end

    // read beat carries no data, only the merged answer
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            RREADY    <= 1'b0;
            DVM_FAULT <= 1'b0;
        end
        else
        begin
            RREADY    <= 1'b1;
            DVM_FAULT <= r_hs && RLAST && RRESP[`DVM_RRESP_FAIL];
        end
    end

    // mirror of the tracker count for status
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            PENDING_SYNCS <= 9'h000;
        else
            PENDING_SYNCS <= evt.pending;
    end

    sequence first_part_taken;
        ar_hs && state == A_SEND1 && multi;
    endsequence

    sequence second_part_shown;
        ARVALID && state == A_SEND2;
    endsequence

    AST_ONE_OWN_SYNC: assert property (@(posedge CLK) disable iff (RST)
        (ar_hs && is_sync) |-> !own_sync)
        else $error("second own sync issued before complete");

    AST_NO_OP_WHILE_PENDING: assert property (@(posedge CLK)
        disable iff (RST)
        (state == A_IDLE && !ARVALID ##1 ARVALID && is_op)
        |-> $past(evt.pending) == 9'h000 && !$past(evt.pending_nz))
        else $error("operation started with a received sync pending");

    AST_PART2_BACK_TO_BACK: assert property (@(posedge CLK)
        disable iff (RST)
        first_part_taken |=> second_part_shown
            and (ARADDR == $past(OP_ADDR2)))
        else $error("second part not issued immediately");

    AST_SAME_ID: assert property (@(posedge CLK) disable iff (RST)
        ARVALID |-> ARID == `DVM_ID && ARSNOOP == `DVM_AR_SNOOP)
        else $error("dvm part issued with another id");

    AST_CMPL_NEEDS_PENDING: assert property (@(posedge CLK)
        disable iff (RST)
        (ar_hs && !is_op && !is_sync) |-> evt.pending != 9'h000)
        else $error("complete issued with no received sync");

    AST_CMPL_AFTER_DRAIN: assert property (@(posedge CLK)
        disable iff (RST)
        ($rose(ARVALID) && !is_op && !is_sync) |-> $past(LOCAL_DRAINED))
        else $error("complete chosen before local work drained");

    AST_SYNC_ORDERED: assert property (@(posedge CLK) disable iff (RST)
        (state == A_IDLE && pick_sync) |=> ARVALID && is_sync
            && $past(ar_out) == 4'h0)
        else $error("sync issued ahead of operation answers");

    AST_CMPL_NOT_BLOCKED: assert property (@(posedge CLK)
        disable iff (RST)
        (state == A_IDLE && evt.pending_nz && LOCAL_DRAINED
            && !evt.cmpl_issued
            && ar_out == 4'h0) |=> ARVALID && !is_op && !is_sync)
        else $error("complete held back by own sync or request");

endmodule : dvm_sync_complete_handler

//--- tb/coh_fabric_model.sv
// interconnect stand-in: read address acceptance, read data, snoop ready
`timescale 1ns/1ps
module coh_fabric_model
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // behaviour
    input  wire logic       slow,
    input  wire logic       fail,
    // read address and read data
    input  wire logic       arvalid,
    output logic            arready,
    input  wire logic       rready,
    output logic            rvalid,
    output logic [3:0]      rresp,
    output logic            rlast,
    // snoop response
    input  wire logic       crvalid,
    input  wire logic [4:0] crresp,
    output logic            crready
);
    logic [3:0] cyc;
    int         faults;
    int         owed;
    int         next_owed;

    // one beat owed per part taken
    assign next_owed = owed + (arvalid && arready) - (rvalid && rready);

    // stalls follow a fixed pattern while slow is set
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cyc     <= 4'h0;
            owed    <= 0;
            faults  <= 0;
            arready <= 1'b0;
            crready <= 1'b0;
            rvalid  <= 1'b0;
            rresp   <= 4'h0;
            rlast   <= 1'b0;
        end
        else
        begin
            cyc     <= cyc + 4'h1;
            arready <= !slow || cyc[1:0] == 2'b11;
            crready <= !slow || cyc[0];
            owed    <= next_owed;
            // fault log: count of cannot-perform snoop answers seen
            if (crvalid && crready && crresp == 5'h02)
                faults <= faults + 1;
            rvalid  <= next_owed > 0;
            // idle lines toggle so stale values never look valid
            rresp   <= next_owed > 0 ? (fail ? 4'h2 : 4'h0) : ~rresp;
            rlast   <= next_owed > 0 ? 1'b1 : ~rlast;
        end
    end
endmodule : coh_fabric_model

//--- tb/dvm_sync_complete_handler_test.sv
// self-checking bench for the dvm sync and complete handler
`timescale 1ns/1ps
module dvm_sync_complete_handler_test;
    logic        CLK, RST, OP_REQ, OP_ACK, SYNC_REQ, SYNC_ACK, SYNC_DONE;
    logic        LOCAL_DRAINED, ARVALID, ARREADY, RVALID, RREADY, RLAST;
    logic        ACVALID, ACREADY, CRVALID, CRREADY, INV_VALID, DVM_FAULT;
    logic        slow, fail, more;
    logic [31:0] OP_ADDR, OP_ADDR2, ARADDR, ACADDR, INV_ADDR, a, e;
    logic [3:0]  ARID, ARSNOOP, RRESP, ACSNOOP;
    logic [2:0]  INV_KIND;
    logic [4:0]  CRRESP, carry;
    logic [8:0]  PENDING_SYNCS;
    logic [31:0] ar_q[$], inv_q[$];
    logic [4:0]  cr_q[$];
    int          n_fail, samples_checked, cycles;
    integer      seed;

    dvm_sync_complete_handler i_dvm_sync_complete_handler
    (
        .CLK(CLK), .RST(RST), .OP_REQ(OP_REQ), .OP_ADDR(OP_ADDR),
        .OP_ADDR2(OP_ADDR2), .OP_ACK(OP_ACK), .SYNC_REQ(SYNC_REQ),
        .SYNC_ACK(SYNC_ACK), .SYNC_DONE(SYNC_DONE),
        .LOCAL_DRAINED(LOCAL_DRAINED), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .ARADDR(ARADDR), .ARID(ARID),
        .ARSNOOP(ARSNOOP), .RVALID(RVALID), .RREADY(RREADY),
        .RRESP(RRESP), .RLAST(RLAST), .ACVALID(ACVALID),
        .ACREADY(ACREADY), .ACADDR(ACADDR), .ACSNOOP(ACSNOOP),
        .CRVALID(CRVALID), .CRREADY(CRREADY), .CRRESP(CRRESP),
        .INV_VALID(INV_VALID), .INV_KIND(INV_KIND), .INV_ADDR(INV_ADDR),
        .INV_ADDR2(),
        .DVM_FAULT(DVM_FAULT), .PENDING_SYNCS(PENDING_SYNCS)
    );

    coh_fabric_model i_coh_fabric_model
    (
        .clk(CLK), .rst(RST), .slow(slow), .fail(fail),
        .arvalid(ARVALID), .arready(ARREADY), .rready(RREADY),
        .rvalid(RVALID), .rresp(RRESP), .rlast(RLAST), .crready(CRREADY),
        .crvalid(CRVALID), .crresp(CRRESP)
    );

    initial
    begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end

    task automatic summarize();
        if (n_fail == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    task automatic cmp(input string what, input logic [31:0] exp, got);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    // a two-part message repeats the first part's answer
    task automatic snoop(input logic [31:0] addr);
        logic [4:0] code;
        code = (addr[14:12] == 3'h5 || addr[14:12] == 3'h7) ? 5'h02 : 5'h00;
        if (more)
            code = carry;
        else if (addr[14:12] == 3'h4)
            ar_q.push_back(32'h6000);
        else if (!addr[0] && addr[14:12] < 3'h4)
            inv_q.push_back(addr);
        more = addr[0] && !more;
        carry = code;
        cr_q.push_back(code);
        @(posedge CLK);
        ACVALID <= 1'b1;
        ACADDR <= addr;
        do @(posedge CLK); while (!ACREADY);
        ACVALID <= 1'b0;
        ACADDR <= ~addr;
    endtask : snoop

    // drained goes high after hold cycles with the request held
    task automatic op(input logic [31:0] addr, addr2, input int hold);
        ar_q.push_back(addr);
        if (addr[0])
            ar_q.push_back(addr2);
        @(posedge CLK);
        OP_REQ <= 1'b1;
        OP_ADDR <= addr;
        OP_ADDR2 <= addr2;
        repeat (hold) @(posedge CLK);
        LOCAL_DRAINED <= 1'b1;
        do @(posedge CLK); while (!OP_ACK);
        OP_REQ <= 1'b0;
    endtask : op

    task automatic await(input string what, ref logic sig);
        int n;
        n = 0;
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (sig !== 1'b1 && n < 60);
        cmp(what, 32'h1, {31'h0, sig});
    endtask : await

    // results are matched against the oldest note as they appear
    always @(posedge CLK)
    begin
        if (!RST && ARVALID && ARREADY)
        begin
            cmp("arid", 32'hf, {28'h0, ARID});
            cmp("arsnoop", 32'hf, {28'h0, ARSNOOP});
            if (ar_q.size() == 0)
                cmp("unexpected ar", 32'h0, 32'h1);
            else
                cmp("araddr", ar_q.pop_front(), ARADDR);
        end
        if (!RST && CRVALID && CRREADY)
            cmp("crresp", cr_q.pop_front(), CRRESP);
        if (!RST && INV_VALID && inv_q.size() == 0)
            cmp("unexpected inv", 32'h0, 32'h1);
        else if (!RST && INV_VALID)
        begin
            e = inv_q.pop_front();
            cmp("inv_addr", e, INV_ADDR);
            cmp("inv_kind", {29'h0, e[14:12]}, {29'h0, INV_KIND});
        end
        cycles++;
        if (cycles > 20000)
        begin
            n_fail++;
            summarize();
        end
    end

    initial
    begin
        seed = 33887;
        RST = 1'b1;
        {OP_REQ, SYNC_REQ, ACVALID, slow, fail, more} = 6'h00;
        {OP_ADDR, OP_ADDR2, ACADDR} = 96'h0;
        LOCAL_DRAINED = 1'b1;
        ACSNOOP = 4'hf;
        repeat (16) @(posedge CLK);
        RST <= 1'b0;
        // every message type, then a two-part unsupported one
        for (int t = 0; t < 8; t++)
            snoop({17'h0, t[2:0], 12'h0});
        snoop(32'h5001);
        snoop(32'h0abc0);
        // random operations, single and two-part, prompt and stalled
        for (int i = 0; i < 6; i++)
        begin
            slow <= i[0];
            a = $random(seed);
            a[14:12] = 3'h0;
            op(a, $random(seed), 0);
        end
        // received syncs hold back operations until work drains
        LOCAL_DRAINED <= 1'b0;
        snoop(32'h4000);
        snoop(32'h4000);
        snoop(32'h0);
        repeat (3) @(posedge CLK);
        cmp("pending", 32'h2, {23'h0, PENDING_SYNCS});
        op(32'h1, 32'h55, 12);
        repeat (3) @(posedge CLK);
        cmp("pending", 32'h0, {23'h0, PENDING_SYNCS});
        // own sync open while a received one completes
        ar_q.push_back(32'h4000);
        SYNC_REQ <= 1'b1;
        await("sync_ack", SYNC_ACK);
        SYNC_REQ <= 1'b0;
        snoop(32'h4000);
        repeat (8) @(posedge CLK);
        snoop(32'h6000);
        await("sync_done", SYNC_DONE);
        // merged failing answer is reported
        fail <= 1'b1;
        fork
            op(32'h1000, 32'h0, 0);
            await("dvm_fault", DVM_FAULT);
        join
        fail <= 1'b0;
        repeat (10) @(posedge CLK);
        cmp("left", 32'h0,
            ar_q.size() + cr_q.size() + inv_q.size());
        cmp("faults", 32'h4, i_coh_fabric_model.faults);
        summarize();
    end
endmodule : dvm_sync_complete_handler_test
